// File: design/rba_pkg.sv
package rba_pkg;
	localparam int RBA_NUM_CHAN = 8;
	localparam int RBA_ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] RBA_OFFSET_ADDR = 8'h00;
	localparam logic [7:0] RBA_LOW_LEVEL_ADDR = 8'h04;
	localparam logic [7:0] RBA_FC_ENABLE_ADDR = 8'h08;
	localparam logic [7:0] RBA_PAUSE_BASE = 8'h20;
	localparam logic [7:0] RBA_FREE_BASE = 8'h40;
	// Field positions
	localparam int RBA_OFFSET_MSB = 15;
	localparam int RBA_LEVEL_MSB = 7;
	localparam int RBA_COUNT_MSB = 15;
	// Reset values
	localparam logic [15:0] RBA_OFFSET_RST = 16'h0000;
	localparam logic [7:0] RBA_LEVEL_RST = 8'h00;
	localparam logic [15:0] RBA_COUNT_RST = 16'h0000;
	localparam logic [7:0] RBA_FC_EN_RST = 8'h00;
endpackage

// File: design/rba_rx_buffer_accounting.sv
// Overview of operation
// [R1] - Copy the 16-bit global offset into each first frame descriptor.
// [R2] - Frame data is placed after skipping offset bytes in first buffer.
// [R3] - Offset zero means data starts at buffer byte one.
// [R4] - Offset fifteen skips fifteen bytes; data starts at byte sixteen.
// [R5] - One offset value serves every receive channel.
// [R6] - One global 8-bit low priority drop level, reset zero.
// [R7] - Software leaves drop level zero when no filtering is wanted.
// [R8] - Eight per-channel 8-bit pause levels, reset zero.
// [R9] - Drop level is compared with the channel free slot count.
// [R10] - Pause level compared with channel free count when enabled.
// [R11] - Writing a free count adds the value; count resets zero.
// [R12] - Free counts wrap on overflow, no saturation or error.
// [R13] - Software first loads each free count with available buffers.
// [R14] - Each received frame subtracts its buffer count from its channel.
// [R15] - Software writes back released buffers to replenish the count.
// [R16] - Low priority frame dropped when count below nonzero level.
// [R17] - Pause asserted while count below level, released when recovered.
//
// Implementation choices: register access over APB and the placing of the registers.
module rba_rx_buffer_accounting
#(
	parameter int NUM_CHAN = rba_pkg::RBA_NUM_CHAN
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rba_pkg::RBA_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_done,
	input wire logic [2:0] frame_chan,
	input wire logic [15:0] frame_bufs,
	input wire logic frame_low_prio,
	output logic [15:0] desc_data_start_offset,
	output logic frame_accept,
	output logic frame_drop,
	output logic [NUM_CHAN-1:0] chan_pause
);
	import rba_pkg::*;

	logic [15:0] offset_r;
	logic [7:0] drop_level_r;
	logic [7:0] fc_enable_r;
	logic [7:0] pause_level_r [NUM_CHAN];
	logic [15:0] free_r [NUM_CHAN];
	logic [15:0] free_nxt [NUM_CHAN];
	logic wr_access;
	logic rd_access;
	logic addr_ok;
	logic [31:0] rd_mux;
	logic drop_now;

	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;

	// Single wait-free access: ready rises in access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	// Read mux and address decode
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		addr_ok = 1'b0;
		if (paddr == RBA_OFFSET_ADDR)
		begin
			rd_mux = {16'h0000, offset_r};
			addr_ok = 1'b1;
		end
		else if (paddr == RBA_LOW_LEVEL_ADDR)
		begin
			rd_mux = {24'h000000, drop_level_r};
			addr_ok = 1'b1;
		end
		else if (paddr == RBA_FC_ENABLE_ADDR)
		begin
			rd_mux = {24'h000000, fc_enable_r};
			addr_ok = 1'b1;
		end
		for (int i = 0; i < NUM_CHAN; i++)
		begin
			if (paddr == RBA_PAUSE_BASE + 8'(4 * i))
			begin
				rd_mux = {24'h000000, pause_level_r[i]};
				addr_ok = 1'b1;
			end
			if (paddr == RBA_FREE_BASE + 8'(4 * i))
			begin
				rd_mux = {16'h0000, free_r[i]};
				addr_ok = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= !addr_ok;
		end
	end

	// Global offset, one value for all channels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			offset_r <= RBA_OFFSET_RST;
		else if (wr_access && pready && paddr == RBA_OFFSET_ADDR)
		begin
			if (pstrb[0])
				offset_r[7:0] <= pwdata[7:0]; // [R5]
			if (pstrb[1])
				offset_r[15:8] <= pwdata[15:8]; // [R5]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drop_level_r <= RBA_LEVEL_RST; // [R6]
			fc_enable_r <= RBA_FC_EN_RST;
		end
		else if (wr_access && pready && pstrb[0])
		begin
			if (paddr == RBA_LOW_LEVEL_ADDR)
				drop_level_r <= pwdata[RBA_LEVEL_MSB:0]; // [R6]
			if (paddr == RBA_FC_ENABLE_ADDR)
				fc_enable_r <= pwdata[7:0];
		end
	end

	// Next free count: add software write, subtract frame buffers
	always_comb
	begin
		for (int i = 0; i < NUM_CHAN; i++)
		begin
			free_nxt[i] = free_r[i];
			if (wr_access && pready && paddr == RBA_FREE_BASE + 8'(4 * i))
				free_nxt[i] = free_nxt[i] + {pstrb[1] ? pwdata[15:8] : 8'h00,
					pstrb[0] ? pwdata[7:0] : 8'h00}; // [R11] [R12]
			if (frame_done && frame_chan == 3'(i))
				free_nxt[i] = free_nxt[i] - frame_bufs; // [R14]
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_chan
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pause_level_r[g] <= RBA_LEVEL_RST; // [R8]
					free_r[g] <= RBA_COUNT_RST; // [R11]
					chan_pause[g] <= 1'b0;
				end
				else
				begin
					if (wr_access && pready && pstrb[0]
						&& paddr == RBA_PAUSE_BASE + 8'(4 * g))
						pause_level_r[g] <= pwdata[RBA_LEVEL_MSB:0]; // [R8]
					free_r[g] <= free_nxt[g]; // [R12] [R14]
					chan_pause[g] <= fc_enable_r[g]
						&& (free_r[g] < {8'h00, pause_level_r[g]}); // [R10] [R17]
				end
			end
			AST_PAUSE_LEVEL: assert property ( // [R8]
				@(posedge pclk) disable iff (!presetn)
				wr_access && pstrb[0] && paddr == RBA_PAUSE_BASE + 8'(4 * g)
				|=> pause_level_r[g] == $past(pwdata[RBA_LEVEL_MSB:0]))
				else $error("pause level write lost");
			AST_PAUSE: assert property ( // [R17]
				@(posedge pclk) disable iff (!presetn)
				1'b1 |=> chan_pause[g] == $past(fc_enable_r[g]
				&& free_r[g] < {8'h00, pause_level_r[g]}))
				else $error("pause state wrong");
			AST_NO_PAUSE_DIS: assert property ( // [R10]
				@(posedge pclk) disable iff (!presetn)
				!fc_enable_r[g] |=> !chan_pause[g])
				else $error("pause while disabled");
		end
	endgenerate

	// Low priority filter decision for the arriving frame
	assign drop_now = frame_low_prio && (drop_level_r != 8'h00)
		&& (free_r[frame_chan] < {8'h00, drop_level_r}); // [R9] [R16]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_accept <= 1'b0;
			frame_drop <= 1'b0;
			desc_data_start_offset <= RBA_OFFSET_RST;
		end
		else
		begin
			frame_accept <= frame_done && !drop_now; // [R16]
			frame_drop <= frame_done && drop_now; // [R16]
			if (frame_done)
				desc_data_start_offset <= offset_r; // [R1] [R2] [R3] [R4]
		end
	end

	// Named steps of a register transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ready_pulse;
		pready ##1 !pready;
	endsequence
	sequence s_offset_write;
		wr_access && pready && paddr == RBA_OFFSET_ADDR && pstrb == 4'hf;
	endsequence
	sequence s_level_write;
		wr_access && pready && paddr == RBA_LOW_LEVEL_ADDR && pstrb[0];
	endsequence
	sequence s_free0_write;
		wr_access && pready && paddr == RBA_FREE_BASE && pstrb == 4'hf
		&& !frame_done;
	endsequence

	AST_READY_PULSE: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_setup |=> s_ready_pulse)
		else $error("ready not one cycle after setup");
	AST_BAD_ADDR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_access || wr_access) && pready && !addr_ok
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_OFFSET_WRITE: assert property ( // [R5]
		@(posedge pclk) disable iff (!presetn)
		s_offset_write |=> offset_r == $past(pwdata[RBA_OFFSET_MSB:0]))
		else $error("offset write lost");
	AST_LEVEL_WRITE: assert property ( // [R6]
		@(posedge pclk) disable iff (!presetn)
		s_level_write |=> drop_level_r == $past(pwdata[RBA_LEVEL_MSB:0]))
		else $error("drop level write lost");
	AST_DESC_OFFSET: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		frame_done |=> desc_data_start_offset == $past(offset_r))
		else $error("descriptor offset not copied");
	AST_ZERO_OFFSET: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		frame_done && offset_r == 16'h0000
		|=> desc_data_start_offset == 16'h0000)
		else $error("zero offset not passed");
	AST_FIFTEEN: assert property ( // [R4]
		@(posedge pclk) disable iff (!presetn)
		frame_done && offset_r == 16'h000f
		|=> desc_data_start_offset == 16'h000f)
		else $error("offset fifteen not passed");
	AST_OFFSET_HOLD: assert property ( // [R2]
		@(posedge pclk) disable iff (!presetn)
		!frame_done |=> $stable(desc_data_start_offset))
		else $error("offset changed without frame");
	AST_INCREMENT: assert property ( // [R11]
		@(posedge pclk) disable iff (!presetn)
		s_free0_write |=> free_r[0]
		== 16'($past(free_r[0]) + $past(pwdata[RBA_COUNT_MSB:0])))
		else $error("free count not incremented");
	AST_DECREMENT: assert property ( // [R14]
		@(posedge pclk) disable iff (!presetn)
		frame_done && frame_chan == 3'd0
		&& !(wr_access && paddr == RBA_FREE_BASE)
		|=> free_r[0] == 16'($past(free_r[0]) - $past(frame_bufs)))
		else $error("free count not decremented");
	AST_WRAP: assert property ( // [R12]
		@(posedge pclk) disable iff (!presetn)
		s_free0_write ##0 (free_r[0] == 16'hffff
		&& pwdata[15:0] == 16'h0001) |=> free_r[0] == 16'h0000)
		else $error("free count did not wrap");
	AST_DROP: assert property ( // [R16]
		@(posedge pclk) disable iff (!presetn)
		frame_done |=> frame_drop == $past(frame_low_prio
		&& drop_level_r != 8'h00
		&& free_r[frame_chan] < {8'h00, drop_level_r}))
		else $error("drop decision wrong");
	AST_ZERO_LEVEL: assert property ( // [R9]
		@(posedge pclk) disable iff (!presetn)
		frame_done && drop_level_r == 8'h00 |=> frame_accept)
		else $error("frame dropped with level zero");
endmodule

// File: bench/rba_rx_buffer_accounting_tb_top.sv
module rba_rx_buffer_accounting_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rba_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd_v;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, err_v, frame_accept, frame_drop;
	logic frame_done = 0, frame_low_prio = 0;
	logic [2:0] frame_chan = 0;
	logic [15:0] frame_bufs = 0, desc_data_start_offset;
	logic [7:0] chan_pause;
	int n_fail = 0, n_tests = 0, cyc = 0;
	rba_rx_buffer_accounting #(.NUM_CHAN(8)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_done(frame_done),
		.frame_chan(frame_chan), .frame_bufs(frame_bufs),
		.frame_low_prio(frame_low_prio), .frame_accept(frame_accept),
		.desc_data_start_offset(desc_data_start_offset),
		.frame_drop(frame_drop), .chan_pause(chan_pause));
	always #4 pclk = ~pclk;
	task give_verdict;
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task frame(input logic [2:0] c, input logic [15:0] b, input logic lp);
		@(posedge pclk);
		frame_done <= 1'b1;
		frame_chan <= c;
		frame_bufs <= b;
		frame_low_prio <= lp;
		@(posedge pclk);
		frame_done <= 1'b0;
		#1;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			apb(0, RBA_PAUSE_BASE + 8'(4 * i), 0);
			chk(rd_v, 0);
			apb(0, RBA_FREE_BASE + 8'(4 * i), 0);
			chk(rd_v, 0);
		end
		apb(0, RBA_LOW_LEVEL_ADDR, 0);
		chk(rd_v, 0);
		apb(1, RBA_OFFSET_ADDR, 32'hffff000f);
		apb(0, RBA_OFFSET_ADDR, 0);
		chk(rd_v, 32'h0000000f);
		frame(3'h7, 0, 0);
		chk(32'(desc_data_start_offset), 32'h000f);
		chk(32'({frame_accept, frame_drop}), 32'h2);
		apb(1, RBA_OFFSET_ADDR, 0);
		frame(3'h0, 0, 0);
		chk(32'(desc_data_start_offset), 0);
		// Free count of channel 2: adds, wraps, decrements
		apb(1, RBA_FREE_BASE + 8'h08, 32'h5);
		apb(1, RBA_FREE_BASE + 8'h08, 32'h3);
		apb(0, RBA_FREE_BASE + 8'h08, 0);
		chk(rd_v, 32'h8);
		apb(1, RBA_FREE_BASE + 8'h08, 32'hfffa);
		apb(0, RBA_FREE_BASE + 8'h08, 0);
		chk(rd_v, 32'h2);
		apb(1, RBA_FREE_BASE + 8'h08, 32'h6);
		frame(3'h2, 16'h3, 0);
		apb(0, RBA_FREE_BASE + 8'h08, 0);
		chk(rd_v, 32'h5);
		apb(0, RBA_FREE_BASE + 8'h0c, 0);
		chk(rd_v, 0);
		// Free count of channel 0: wraps, then replenish and decrement
		apb(1, RBA_FREE_BASE, 32'hffff);
		apb(1, RBA_FREE_BASE, 32'h1);
		apb(0, RBA_FREE_BASE, 0);
		chk(rd_v, 0);
		apb(1, RBA_FREE_BASE, 32'h4);
		frame(3'h0, 16'h2, 0);
		apb(0, RBA_FREE_BASE, 0);
		chk(rd_v, 32'h2);
		// Low priority filtering around the level
		apb(1, RBA_LOW_LEVEL_ADDR, 32'hffffff06);
		apb(0, RBA_LOW_LEVEL_ADDR, 0);
		chk(rd_v, 32'h6);
		frame(3'h2, 16'h1, 1);
		chk(32'({frame_accept, frame_drop}), 32'h1);
		frame(3'h2, 16'h1, 0);
		chk(32'({frame_accept, frame_drop}), 32'h2);
		apb(1, RBA_LOW_LEVEL_ADDR, 32'h3);
		frame(3'h2, 0, 1);
		chk(32'({frame_accept, frame_drop}), 32'h2);
		apb(1, RBA_LOW_LEVEL_ADDR, 0);
		frame(3'h3, 0, 1);
		chk(32'({frame_accept, frame_drop}), 32'h2);
		// Pause of channel 2, count now 3
		apb(1, RBA_PAUSE_BASE + 8'h08, 32'hffffff04);
		apb(0, RBA_PAUSE_BASE + 8'h08, 0);
		chk(rd_v, 32'h4);
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(chan_pause), 0);
		apb(1, RBA_FC_ENABLE_ADDR, 32'h04);
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(chan_pause), 32'h04);
		apb(1, RBA_FREE_BASE + 8'h08, 32'h1);
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(chan_pause), 0);
		// Unmapped address
		apb(0, 8'h10, 0);
		chk(32'({err_v, rd_v}), 32'h0);
		chk(32'(err_v), 32'h1);
		// Reset in mid-run clears counts and levels
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, RBA_FREE_BASE + 8'h08, 0);
		chk(rd_v, 0);
		apb(0, RBA_PAUSE_BASE + 8'h08, 0);
		chk(rd_v, 0);
		give_verdict();
	end
endmodule
